// >>> logic/power_mode_pkg.sv
// Constants, types and state encodings of the chip power mode controller
// ----------------------------------------------------------------------
// Notes on behaviour
// [RULE1] Reset leaves chip in normal run, regulator on
// [RULE2] Wait-for-interrupt instruction enters every wait or stop
// [RULE3] Each run mode has wait and stop
// [RULE4] Pin states held in every mode
// [RULE5] Normal wait: core sleeps, any interrupt wakes
// [RULE6] Normal stop: clocks stop, detection on, async wake
// [RULE7] Very low power run: 1 MHz flash, 2 MHz clock
// [RULE8] Very low power wait: core sleeps, interrupt wakes
// [RULE9] Very low power stop: fast clock off, async wake
// [RULE10] Low leakage stop: wakeup unit interrupt resumes run
// [RULE11] Software keeps wakeup unit interrupt unmasked
// [RULE12] Level 3: both SRAM kept, wake by reset
// [RULE13] Level 2: lower SRAM off, upper partial
// [RULE14] Level 1: SRAM off, register files kept
// [RULE15] Battery only: needs full power-up sequence
// [RULE16] Wakeup reset keeps wakeup unit flag set
// [RULE17] Stop selection latched at instruction time
// ----------------------------------------------------------------------
package power_mode_pkg;

   // ----------------------------------------------------------------
   // Stop selection codes
   // ----------------------------------------------------------------
   localparam logic [2:0] SEL_NORMAL_STOP  = 3'h0;
   localparam logic [2:0] SEL_LOW_LEAKAGE  = 3'h1;
   localparam logic [2:0] SEL_VERY_LOW_LEAKAGE_STOP_LEVEL3        = 3'h2;
   localparam logic [2:0] SEL_VERY_LOW_LEAKAGE_STOP_LEVEL2        = 3'h3;
   localparam logic [2:0] SEL_VERY_LOW_LEAKAGE_STOP_LEVEL1        = 3'h4;
   localparam logic [2:0] SEL_BATTERY_ONLY = 3'h5;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ             = 25_000_000;
   localparam int FLASH_LOW_HZ       = 1_000_000;
   localparam int SLOW_OSC_HZ        = 2_000_000;
   localparam int FLASH_DIV_CYCLES   = CLK_HZ / FLASH_LOW_HZ;
   localparam int SLOW_DIV_CYCLES    = CLK_HZ / SLOW_OSC_HZ;
   localparam int WAKE_RESET_CYCLES  = 16;
   localparam int REG_FILE_BYTES     = 32;

   typedef enum logic [10:0] {
      ST_RUN        = 11'h001,
      ST_WAIT       = 11'h002,
      ST_STOP       = 11'h004,
      ST_VLP_RUN    = 11'h008,
      ST_VLP_WAIT   = 11'h010,
      ST_VLP_STOP   = 11'h020,
      ST_LLS        = 11'h040,
      ST_VERY_LOW_LEAKAGE_STOP_LEVEL3      = 11'h080,
      ST_VERY_LOW_LEAKAGE_STOP_LEVEL2      = 11'h100,
      ST_VERY_LOW_LEAKAGE_STOP_LEVEL1      = 11'h200,
      ST_BATTERY    = 11'h400
   } power_state_t;

   typedef struct packed {
      logic request_wfi;
      logic sleep_deep;
      logic [2:0] stop_select;
      logic want_vlp_run;
   } core_request_t;

   typedef struct packed {
      logic regulator_on;
      logic regulator_low_power;
      logic core_clock_on;
      logic periph_clock_on;
      logic fast_clock_on;
      logic lvd_enable;
      logic nested_interrupt_controller_enable;
      logic async_wakeup_interrupt_controller_enable;
      logic low_leakage_wakeup_unit_enable;
      logic flash_slow_mode;
      logic slow_clock_select;
      logic sram_lower_on;
      logic sram_upper_full_on;
      logic sram_upper_part_on;
      logic reg_files_on;
      logic main_domain_on;
      logic io_hold;
   } power_controls_t;

endpackage

// >>> logic/wake_reset_timer.sv
// Pulse stretcher that forms the wake-up reset for the normal reset flow
module wake_reset_timer
   import power_mode_pkg::*;
#(
   parameter int LENGTH = WAKE_RESET_CYCLES
)(
   input  wire logic clk_sys,
   input  wire logic reset,
   input  wire logic start,
   output logic      reset_out
);

   logic [7:0] count_reg;
   logic [7:0] count_next;

   always_comb
   begin
      count_next = count_reg;
      if (start)
      begin
         count_next = 8'(LENGTH);
      end
      else if (count_reg != 8'h00)
      begin
         count_next = count_reg - 8'h01;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         count_reg <= 8'h00;
      end
      else
      begin
         count_reg <= count_next;
      end
   end

   assign reset_out = (count_reg != 8'h00);

endmodule

// >>> logic/chip_power_mode_controller.sv
// Chip power mode state machine with per-mode control outputs
module chip_power_mode_controller
   import power_mode_pkg::*;
(
   input  wire logic            clk_sys,
   input  wire logic            reset,
   input  wire core_request_t   core_req,
   input  wire logic            irq_pending,
   input  wire logic            async_wake_pin,
   input  wire logic            low_leakage_wakeup_unit_wake_pin,
   input  wire logic            power_up_pin,
   input  wire logic            low_leakage_wakeup_unit_flag_clear,
   output power_controls_t      controls,
   output power_state_t         mode,
   output logic                 wake_reset,
   output logic                 low_leakage_wakeup_unit_flag,
   output logic                 flash_clock_tick,
   output logic                 slow_clock_tick
);

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [2:0] sync1_reg;
   logic [2:0] sync2_reg;
   logic       async_wake_s;
   logic       low_leakage_wakeup_unit_wake_s;
   logic       power_up_s;

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         sync1_reg <= 3'h0;
         sync2_reg <= 3'h0;
      end
      else
      begin
         sync1_reg <= {power_up_pin, low_leakage_wakeup_unit_wake_pin, async_wake_pin};
         sync2_reg <= sync1_reg;
      end
   end

   assign async_wake_s = sync2_reg[0];
   assign low_leakage_wakeup_unit_wake_s  = sync2_reg[1];
   assign power_up_s   = sync2_reg[2];

   // ----------------------------------------------------------------
   // Mode state machine
   // ----------------------------------------------------------------
   power_state_t    state_reg;
   power_state_t    state_next;
   logic            flag_reg;
   logic            flag_next;
   logic            wake_start;
   logic            wake_rst;

   function automatic power_state_t deep_target(input logic [2:0] sel);
      case (sel)
         SEL_LOW_LEAKAGE:  deep_target = ST_LLS;
         SEL_VERY_LOW_LEAKAGE_STOP_LEVEL3:        deep_target = ST_VERY_LOW_LEAKAGE_STOP_LEVEL3;
         SEL_VERY_LOW_LEAKAGE_STOP_LEVEL2:        deep_target = ST_VERY_LOW_LEAKAGE_STOP_LEVEL2;
         SEL_VERY_LOW_LEAKAGE_STOP_LEVEL1:        deep_target = ST_VERY_LOW_LEAKAGE_STOP_LEVEL1;
         SEL_BATTERY_ONLY: deep_target = ST_BATTERY;
         default:          deep_target = ST_STOP;
      endcase
   endfunction

   always_comb
   begin
      state_next = state_reg;
      wake_start = 1'b0;
      flag_next  = flag_reg;
      if (low_leakage_wakeup_unit_flag_clear)
      begin
         flag_next = 1'b0;
      end
      case (state_reg)
         ST_RUN:
         begin
            if (core_req.request_wfi)                  // [RULE2] [RULE17]
            begin
               if (!core_req.sleep_deep)
               begin
                  state_next = ST_WAIT;                        // [RULE3]
               end
               else
               begin
                  state_next = deep_target(core_req.stop_select);
               end
            end
            else if (core_req.want_vlp_run)
            begin
               state_next = ST_VLP_RUN;
            end
         end
         ST_VLP_RUN:
         begin
            if (core_req.request_wfi)                  // [RULE2] [RULE17]
            begin
               if (!core_req.sleep_deep)
               begin
                  state_next = ST_VLP_WAIT;                    // [RULE3]
               end
               else if (core_req.stop_select == SEL_NORMAL_STOP)
               begin
                  state_next = ST_VLP_STOP;
               end
               else
               begin
                  state_next = deep_target(core_req.stop_select);
               end
            end
            else if (!core_req.want_vlp_run)
            begin
               state_next = ST_RUN;
            end
         end
         ST_WAIT:
         begin
            if (irq_pending)                                   // [RULE5]
            begin
               state_next = ST_RUN;
            end
         end
         ST_VLP_WAIT:
         begin
            if (irq_pending)                                   // [RULE8]
            begin
               state_next = ST_VLP_RUN;
            end
         end
         ST_STOP:
         begin
            if (async_wake_s)                                  // [RULE6]
            begin
               state_next = ST_RUN;
            end
         end
         ST_VLP_STOP:
         begin
            if (async_wake_s)                                  // [RULE9]
            begin
               state_next = ST_VLP_RUN;
            end
         end
         ST_LLS:
         begin
            if (low_leakage_wakeup_unit_wake_s)                                   // [RULE10]
            begin
               flag_next  = 1'b1;
               state_next = ST_RUN;
            end
         end
         ST_VERY_LOW_LEAKAGE_STOP_LEVEL3, ST_VERY_LOW_LEAKAGE_STOP_LEVEL2, ST_VERY_LOW_LEAKAGE_STOP_LEVEL1:
         begin
            if (low_leakage_wakeup_unit_wake_s)                             // [RULE12] [RULE13]
            begin
               flag_next  = 1'b1;                              // [RULE16]
               wake_start = 1'b1;                              // [RULE14]
               state_next = ST_RUN;
            end
         end
         ST_BATTERY:
         begin
            if (power_up_s)                                    // [RULE15]
            begin
               flag_next  = 1'b0;
               wake_start = 1'b1;
               state_next = ST_RUN;
            end
         end
         default:
         begin
            state_next = ST_RUN;
         end
      endcase
      // A low leakage wakeup that lands with a clear keeps the flag set
      if (wake_start && state_reg != ST_BATTERY)
      begin
         flag_next = 1'b1;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         state_reg <= ST_RUN;                                  // [RULE1]
         flag_reg  <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         flag_reg  <= flag_next;
      end
   end

   wake_reset_timer #(
      .LENGTH    (WAKE_RESET_CYCLES)
   ) u_wake_reset (
      .clk_sys   (clk_sys),
      .reset     (reset),
      .start     (wake_start),
      .reset_out (wake_rst)
   );

   // ----------------------------------------------------------------
   // Reduced rate clock ticks for very low power run
   // ----------------------------------------------------------------
   logic [4:0] flash_cnt_reg;
   logic [4:0] flash_cnt_next;
   logic [3:0] slow_cnt_reg;
   logic [3:0] slow_cnt_next;
   logic       vlp_active;

   assign vlp_active = (state_reg == ST_VLP_RUN) ||
                       (state_reg == ST_VLP_WAIT);

   always_comb
   begin
      flash_cnt_next = 5'h00;
      slow_cnt_next  = 4'h0;
      if (vlp_active)                                          // [RULE7]
      begin
         flash_cnt_next = (flash_cnt_reg == 5'(FLASH_DIV_CYCLES - 1)) ?
                          5'h00 : flash_cnt_reg + 5'h01;
         slow_cnt_next  = (slow_cnt_reg == 4'(SLOW_DIV_CYCLES - 1)) ?
                          4'h0 : slow_cnt_reg + 4'h1;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         flash_cnt_reg <= 5'h00;
         slow_cnt_reg  <= 4'h0;
      end
      else
      begin
         flash_cnt_reg <= flash_cnt_next;
         slow_cnt_reg  <= slow_cnt_next;
      end
   end

   // ----------------------------------------------------------------
   // Registered control outputs
   // ----------------------------------------------------------------
   power_controls_t ctl_next;
   logic            flash_tick_next;
   logic            slow_tick_next;

   always_comb
   begin
      ctl_next = '0;
      ctl_next.io_hold = 1'b1;                                 // [RULE4]
      flash_tick_next = vlp_active && (flash_cnt_reg == 5'h00);
      slow_tick_next  = vlp_active && (slow_cnt_reg == 4'h0);
      case (state_next)
         ST_RUN, ST_WAIT, ST_STOP:
         begin
            ctl_next.regulator_on       = 1'b1;
            ctl_next.lvd_enable         = 1'b1;
            ctl_next.core_clock_on      = (state_next == ST_RUN);
            ctl_next.periph_clock_on    = (state_next != ST_STOP);
            ctl_next.fast_clock_on      = (state_next != ST_STOP);
            ctl_next.nested_interrupt_controller_enable        = (state_next != ST_STOP);
            ctl_next.async_wakeup_interrupt_controller_enable        = (state_next == ST_STOP);
         end
         ST_VLP_RUN, ST_VLP_WAIT, ST_VLP_STOP:
         begin
            ctl_next.regulator_low_power = 1'b1;
            ctl_next.flash_slow_mode     = 1'b1;
            ctl_next.slow_clock_select   = 1'b1;
            ctl_next.core_clock_on       = (state_next == ST_VLP_RUN);
            ctl_next.periph_clock_on     = (state_next != ST_VLP_STOP);
            ctl_next.fast_clock_on       = (state_next != ST_VLP_STOP);
            ctl_next.nested_interrupt_controller_enable         = (state_next != ST_VLP_STOP);
            ctl_next.async_wakeup_interrupt_controller_enable         = (state_next == ST_VLP_STOP);
         end
         ST_LLS, ST_VERY_LOW_LEAKAGE_STOP_LEVEL3, ST_VERY_LOW_LEAKAGE_STOP_LEVEL2, ST_VERY_LOW_LEAKAGE_STOP_LEVEL1:
         begin
            ctl_next.regulator_low_power = 1'b1;
            ctl_next.low_leakage_wakeup_unit_enable         = 1'b1;
         end
         default:
         begin
         end
      endcase
      // SRAM and domain power, low leakage levels peel away in order
      ctl_next.main_domain_on = (state_next != ST_BATTERY);
      ctl_next.sram_lower_on  = (state_next != ST_VERY_LOW_LEAKAGE_STOP_LEVEL2) &&
                                (state_next != ST_VERY_LOW_LEAKAGE_STOP_LEVEL1) &&
                                (state_next != ST_BATTERY);
      ctl_next.sram_upper_full_on = ctl_next.sram_lower_on;
      ctl_next.sram_upper_part_on = ctl_next.sram_lower_on ||
                                    (state_next == ST_VERY_LOW_LEAKAGE_STOP_LEVEL2);
      ctl_next.reg_files_on   = (state_next != ST_BATTERY);
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         controls         <= '0;
         controls.regulator_on  <= 1'b1;                       // [RULE1]
         controls.core_clock_on <= 1'b1;
         controls.periph_clock_on <= 1'b1;
         controls.fast_clock_on <= 1'b1;
         controls.lvd_enable    <= 1'b1;
         controls.nested_interrupt_controller_enable   <= 1'b1;
         controls.sram_lower_on <= 1'b1;
         controls.sram_upper_full_on <= 1'b1;
         controls.sram_upper_part_on <= 1'b1;
         controls.reg_files_on  <= 1'b1;
         controls.main_domain_on <= 1'b1;
         controls.io_hold       <= 1'b1;
         mode             <= ST_RUN;
         wake_reset       <= 1'b0;
         low_leakage_wakeup_unit_flag        <= 1'b0;
         flash_clock_tick <= 1'b0;
         slow_clock_tick  <= 1'b0;
      end
      else
      begin
         controls         <= ctl_next;
         mode             <= state_reg;
         wake_reset       <= wake_rst;
         low_leakage_wakeup_unit_flag        <= flag_reg;
         flash_clock_tick <= flash_tick_next;
         slow_clock_tick  <= slow_tick_next;
      end
   end

endmodule

// >>> verification/chip_power_mode_controller_asserts.sv
// Checker for the chip power mode controller, bound to its ports
module chip_power_mode_controller_asserts
   import power_mode_pkg::*;
(
   input wire logic            clk_sys,
   input wire logic            reset,
   input wire power_controls_t controls,
   input wire power_state_t    mode,
   input wire logic            wake_reset
);
   power_controls_t p_reg;

   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (reset);

   // Controls lead mode by one cycle, so mode is judged on the old copy
   always_ff @(posedge clk_sys)
   begin
      p_reg <= controls;
   end

   a_reset_run: assert property (
      $fell(reset) |-> mode == ST_RUN && controls.regulator_on)
      else $error("not in run after reset");
   a_io_held: assert property (
      controls.io_hold)
      else $error("pin hold dropped");
   a_wait_ctl: assert property (
      mode == ST_WAIT |-> !p_reg.core_clock_on && p_reg.periph_clock_on
         && p_reg.nested_interrupt_controller_enable)
      else $error("wait controls wrong");
   a_stop_ctl: assert property (
      mode == ST_STOP |-> !p_reg.periph_clock_on && p_reg.lvd_enable
         && !p_reg.nested_interrupt_controller_enable && p_reg.async_wakeup_interrupt_controller_enable)
      else $error("stop controls wrong");
   a_very_low_power_run_ctl: assert property (
      mode == ST_VLP_RUN |-> p_reg.regulator_low_power
         && !p_reg.lvd_enable && p_reg.flash_slow_mode
         && p_reg.slow_clock_select)
      else $error("slow run controls wrong");
   a_very_low_power_wait_ctl: assert property (
      mode == ST_VLP_WAIT |-> p_reg.fast_clock_on && p_reg.nested_interrupt_controller_enable
         && !p_reg.core_clock_on)
      else $error("slow wait controls wrong");
   a_very_low_power_stop_ctl: assert property (
      mode == ST_VLP_STOP |-> !p_reg.fast_clock_on && !p_reg.lvd_enable
         && p_reg.async_wakeup_interrupt_controller_enable)
      else $error("slow stop controls wrong");
   a_lls_ctl: assert property (
      mode == ST_LLS |-> p_reg.low_leakage_wakeup_unit_enable && !p_reg.nested_interrupt_controller_enable
         && p_reg.sram_lower_on && p_reg.sram_upper_full_on)
      else $error("leakage stop controls wrong");
   a_level3_ram: assert property (
      mode == ST_VERY_LOW_LEAKAGE_STOP_LEVEL3 |-> p_reg.sram_lower_on && p_reg.sram_upper_full_on)
      else $error("level 3 memory off");
   a_level2_ram: assert property (
      mode == ST_VERY_LOW_LEAKAGE_STOP_LEVEL2 |-> !p_reg.sram_lower_on && p_reg.sram_upper_part_on)
      else $error("level 2 memory wrong");
   a_level1_ram: assert property (
      mode == ST_VERY_LOW_LEAKAGE_STOP_LEVEL1 |-> !p_reg.sram_lower_on && !p_reg.sram_upper_part_on
         && !p_reg.sram_upper_full_on && p_reg.reg_files_on)
      else $error("level 1 memory wrong");
   a_battery_off: assert property (
      mode == ST_BATTERY |-> !p_reg.main_domain_on)
      else $error("main domain on in battery state");

   c_lls: cover property (mode == ST_LLS);
   c_vlp_stop: cover property (mode == ST_VLP_STOP);
   c_wake_reset: cover property ($rose(wake_reset));
endmodule

bind chip_power_mode_controller chip_power_mode_controller_asserts chk (
   .clk_sys(clk_sys),
   .reset(reset),
   .controls(controls),
   .mode(mode),
   .wake_reset(wake_reset)
);

// >>> verification/core_model.sv
// Processor core and wake-up source model on the controller's far side
module core_model
   import power_mode_pkg::*;
(
   input  wire logic     clk_sys,
   input  wire logic     low_leakage_wakeup_unit_flag,
   output core_request_t core_req,
   output logic          irq_pending,
   output logic          async_wake_pin,
   output logic          low_leakage_wakeup_unit_wake_pin,
   output logic          power_up_pin,
   output logic          low_leakage_wakeup_unit_flag_clear
);
   timeunit 1ns;
   timeprecision 1ps;

   logic irq_level;

   // Software leaves the wakeup unit interrupt unmasked, so its flag pends
   assign irq_pending = irq_level | low_leakage_wakeup_unit_flag;

   initial
   begin
      core_req = '0;
      irq_level = 1'b0;
      async_wake_pin = 1'b0;
      low_leakage_wakeup_unit_wake_pin = 1'b0;
      power_up_pin = 1'b0;
      low_leakage_wakeup_unit_flag_clear = 1'b0;
   end

   // Selection is scrambled after the pulse, so only a latch can keep it
   task automatic wait_for_interrupt_instruction(input logic deep, input logic [2:0] sel);
      @(negedge clk_sys);
      core_req.sleep_deep = deep;
      core_req.stop_select = sel;
      @(negedge clk_sys);
      core_req.request_wfi = 1'b1;
      @(negedge clk_sys);
      core_req.request_wfi = 1'b0;
      core_req.stop_select = ~sel;
   endtask

   task automatic vlp(input logic on);
      @(negedge clk_sys);
      core_req.want_vlp_run = on;
   endtask

   // Causes are levels held until the bench drops them
   task automatic raise(input int cause);
      @(negedge clk_sys);
      case (cause)
         0: irq_level = 1'b1;
         1: async_wake_pin = 1'b1;
         2: low_leakage_wakeup_unit_wake_pin = 1'b1;
         default: power_up_pin = 1'b1;
      endcase
   endtask

   task automatic drop();
      @(negedge clk_sys);
      irq_level = 1'b0;
      async_wake_pin = 1'b0;
      low_leakage_wakeup_unit_wake_pin = 1'b0;
      power_up_pin = 1'b0;
   endtask

   task automatic clear_flag();
      @(negedge clk_sys);
      low_leakage_wakeup_unit_flag_clear = 1'b1;
      @(negedge clk_sys);
      low_leakage_wakeup_unit_flag_clear = 1'b0;
   endtask
endmodule

// >>> verification/tb_chip_power_mode_controller.sv
// Self-checking bench for the chip power mode controller
module tb_chip_power_mode_controller
   import power_mode_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;

   logic            clk_sys;
   logic            reset;
   core_request_t   core_req;
   logic            irq_pending;
   logic            async_wake_pin;
   logic            low_leakage_wakeup_unit_wake_pin;
   logic            power_up_pin;
   logic            low_leakage_wakeup_unit_flag_clear;
   power_controls_t controls;
   power_state_t    mode;
   logic            wake_reset;
   logic            low_leakage_wakeup_unit_flag;
   logic            flash_clock_tick;
   logic            slow_clock_tick;
   int              num_errors = 0;
   int              comparisons = 0;

   chip_power_mode_controller dut (
      .clk_sys(clk_sys),
      .reset(reset),
      .core_req(core_req),
      .irq_pending(irq_pending),
      .async_wake_pin(async_wake_pin),
      .low_leakage_wakeup_unit_wake_pin(low_leakage_wakeup_unit_wake_pin),
      .power_up_pin(power_up_pin),
      .low_leakage_wakeup_unit_flag_clear(low_leakage_wakeup_unit_flag_clear),
      .controls(controls),
      .mode(mode),
      .wake_reset(wake_reset),
      .low_leakage_wakeup_unit_flag(low_leakage_wakeup_unit_flag),
      .flash_clock_tick(flash_clock_tick),
      .slow_clock_tick(slow_clock_tick)
   );

   core_model model (
      .clk_sys(clk_sys),
      .low_leakage_wakeup_unit_flag(low_leakage_wakeup_unit_flag),
      .core_req(core_req),
      .irq_pending(irq_pending),
      .async_wake_pin(async_wake_pin),
      .low_leakage_wakeup_unit_wake_pin(low_leakage_wakeup_unit_wake_pin),
      .power_up_pin(power_up_pin),
      .low_leakage_wakeup_unit_flag_clear(low_leakage_wakeup_unit_flag_clear)
   );

   initial
   begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   // ----------------------------------------
   // Comparisons
   // ----------------------------------------
   task automatic chk_bit(input logic got, input logic exp);
      comparisons++;
      if (got !== exp)
      begin
         num_errors++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         num_errors++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic wait_mode(input power_state_t exp);
      int i;
      for (i = 0; i < 40 && mode !== exp; i++) @(negedge clk_sys);
      chk_val(32'(mode), 32'(exp));
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset();
      chk_val(32'(mode), 32'(ST_RUN));
      chk_bit(controls.regulator_on, 1'b1);
      chk_bit(controls.io_hold, 1'b1);
      $display("test reset done");
   endtask

   task automatic t_wait();
      model.wait_for_interrupt_instruction(1'b0, 3'h0);
      wait_mode(ST_WAIT);
      chk_bit(controls.periph_clock_on, 1'b1);
      model.raise(0);
      wait_mode(ST_RUN);
      model.drop();
      $display("test wait done");
   endtask

   task automatic t_vlp();
      int f;
      int s;
      model.vlp(1'b1);
      wait_mode(ST_VLP_RUN);
      f = 0;
      s = 0;
      repeat (300)
      begin
         @(negedge clk_sys);
         if (flash_clock_tick === 1'b1) f++;
         if (slow_clock_tick === 1'b1) s++;
      end
      chk_val(32'(f), 32'(300 / FLASH_DIV_CYCLES));
      chk_val(32'(s), 32'(300 / SLOW_DIV_CYCLES));
      model.wait_for_interrupt_instruction(1'b0, 3'h0);
      wait_mode(ST_VLP_WAIT);
      model.raise(0);
      wait_mode(ST_VLP_RUN);
      model.drop();
      model.wait_for_interrupt_instruction(1'b1, 3'h0);
      wait_mode(ST_VLP_STOP);
      model.raise(1);
      wait_mode(ST_VLP_RUN);
      model.drop();
      model.vlp(1'b0);
      wait_mode(ST_RUN);
      $display("test slow modes done");
   endtask

   // Flag is left set after level 1 so the battery wake must clear it
   task automatic t_stops();
      power_state_t st [6];
      int           src [6];
      int           k;
      int           n;
      st = '{ST_STOP, ST_LLS, ST_VERY_LOW_LEAKAGE_STOP_LEVEL3, ST_VERY_LOW_LEAKAGE_STOP_LEVEL2, ST_VERY_LOW_LEAKAGE_STOP_LEVEL1, ST_BATTERY};
      src = '{1, 2, 2, 2, 2, 3};
      for (k = 0; k < 6; k++)
      begin
         model.wait_for_interrupt_instruction(1'b1, 3'(k));
         wait_mode(st[k]);
         if (k > 0)
         begin
            model.raise(0);
            repeat (8) @(negedge clk_sys);
            chk_val(32'(mode), 32'(st[k]));
            model.drop();
         end
         model.raise(src[k]);
         n = 0;
         repeat (60)
         begin
            @(negedge clk_sys);
            if (wake_reset === 1'b1) n++;
         end
         chk_val(32'(n), (k > 1) ? 32'h10 : 32'h0);
         wait_mode(ST_RUN);
         chk_bit(low_leakage_wakeup_unit_flag, k inside {[1:4]});
         model.drop();
         if (k inside {[1:3]})
         begin
            model.clear_flag();
            @(negedge clk_sys);
            chk_bit(low_leakage_wakeup_unit_flag, 1'b0);
         end
      end
      $display("test stop modes done");
   endtask

   task automatic results();
      $display("comparisons %0d num_errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial
   begin
      reset = 1'b1;
      repeat (4) @(negedge clk_sys);
      reset = 1'b0;
      t_reset();
      t_wait();
      t_vlp();
      t_stops();
      results();
   end

   // About six times the expected run length
   initial
   begin
      #(40 * 5000);
      num_errors++;
      results();
   end
endmodule
